//--- inc/erf_pkg.sv
// Constants, types and helpers shared by the embedded row formatter and its statistics engine.
// Assumes a 12-bit pixel word and 20-bit linear pixel values for statistics.
package erf_pkg;

	// Marker and tag words, already placed in the 12-bit pixel word.
	localparam logic [11:0] TAG_DATA     = 12'h0a0;
	localparam logic [11:0] TAG_STAT     = 12'h0b0;
	localparam logic [11:0] MARK_ADDR_HI = 12'haa0;
	localparam logic [11:0] MARK_ADDR_LO = 12'ha50;
	localparam logic [11:0] MARK_VAL     = 12'h5a0;
	localparam logic [11:0] PAD_WORD     = 12'h000;

	// Ten-bit statistics words.
	localparam logic [9:0] STAT_FMT    = 10'h00b;
	localparam logic [9:0] STAT1_WORDS = 10'h1ec;
	localparam logic [9:0] STAT2_WORDS = 10'h00c;
	localparam logic [9:0] STAT_TERM   = 10'h007;

	// Register ranges carried by the data rows.
	localparam logic [15:0] D1_START  = 16'h3000;
	localparam logic [15:0] D2_START  = 16'h3136;
	localparam logic [15:0] D2B_START = 16'h31d0;
	localparam logic [7:0]  D1_REGS   = 8'h98;
	localparam logic [7:0]  D2A_REGS  = 8'h45;
	localparam logic [7:0]  D2_REGS   = 8'h5d;
	localparam logic [15:0] FCNT_ADDR = 16'h303a;
	localparam logic [15:0] FID_ADDR  = 16'h31d2;

	// Word positions within a row.
	localparam logic [9:0] W_TAG   = 10'h000;
	localparam logic [9:0] W_AMK1  = 10'h001;
	localparam logic [9:0] W_AHI   = 10'h002;
	localparam logic [9:0] W_AMK2  = 10'h003;
	localparam logic [9:0] W_ALO   = 10'h004;
	localparam logic [9:0] W_BODY  = 10'h005;
	localparam logic [9:0] W_FMT   = 10'h001;
	localparam logic [9:0] W_CNT   = 10'h002;
	localparam logic [9:0] W_FCHI  = 10'h003;
	localparam logic [9:0] W_FCLO  = 10'h004;
	localparam logic [9:0] W_IDHI  = 10'h005;
	localparam logic [9:0] W_IDLO  = 10'h006;
	localparam logic [9:0] W_BIN0  = 10'h007;
	localparam logic [9:0] W_TERM1 = 10'h1ef;
	localparam logic [9:0] W_SUM0  = 10'h003;
	localparam logic [9:0] W_TERM2 = 10'h00f;
	localparam logic [11:0] ROWS_LEAD = 12'h002;

	// Histogram layout.
	localparam int          NBINS      = 244;
	localparam logic [19:0] EDGE_LO    = 20'h01000;
	localparam logic [19:0] EDGE_MID   = 20'h10000;
	localparam logic [7:0]  BIN_MID_OF = 8'h38;
	localparam logic [7:0]  BIN_HI_OF  = 8'hb4;

	typedef enum logic [2:0] {ROW_IMG, ROW_D1, ROW_D2, ROW_S1, ROW_S2} erf_row_e;

	typedef struct packed {
		logic        fv;
		logic        lv;
		logic [11:0] pix;
	} erf_vid_s;

	typedef struct packed {
		logic [19:0] mean;
		logic [19:0] hist_first_nonempty;
		logic [19:0] hist_last_nonempty;
		logic [19:0] dark_tail_average;
		logic [19:0] dark_tail_fraction;
		logic [19:0] abs_dev;
	} erf_summ_s;

	function automatic logic [11:0] b8(input logic [7:0] b);
		return {b, 4'h0};
	endfunction : b8

	function automatic logic [11:0] w10(input logic [9:0] w);
		return {w, 2'h0};
	endfunction : w10

	// Bin widths are 64, 512 and 16384 codes in the three regions.
	function automatic logic [7:0] bin_of(input logic [19:0] v);
		if (v < EDGE_LO) begin
			return {2'h0, v[11:6]};
		end
		if (v < EDGE_MID) begin
			return BIN_MID_OF + {1'h0, v[15:9]};
		end
		return BIN_HI_OF + {2'h0, v[19:14]};
	endfunction : bin_of

endpackage : erf_pkg

//--- logic/erf_stats.sv
// Frame statistics engine: ping-pong histogram and summary values of one frame.
// Assumes latch never coincides with acc_en and comes once per frame.
`timescale 1ns/1ps
module erf_stats #(
	parameter int PIX_LOG2 = 20
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               resetn,
	// Accumulation
	input  wire logic               acc_en,
	input  wire logic [19:0]        acc_val,
	input  wire logic               latch,
	// Readout of the latched frame
	input  wire logic [7:0]         rd_idx,
	output logic [19:0]             rd_cnt,
	output erf_pkg::erf_summ_s      summ
);
	logic [19:0]                         mem [2][erf_pkg::NBINS];
	logic [1:0][erf_pkg::NBINS-1:0]      vld_q;
	logic                                bank_q;
	logic                                seen_q;
	logic [7:0]                          first_q;
	logic [7:0]                          last_q;
	logic [39:0]                         sum_q;
	logic [39:0]                         dsum_q;
	logic [39:0]                         dev_q;
	logic [19:0]                         dcnt_q;
	logic [19:0]                         pmean_q;

	wire logic [7:0]  bin    = erf_pkg::bin_of(acc_val);
	wire logic [19:0] cur    = vld_q[bank_q][bin] ? mem[bank_q][bin] : 20'h0;
	wire logic        dark   = acc_val < pmean_q;
	wire logic [19:0] dev    = dark ? pmean_q - acc_val : acc_val - pmean_q;
	wire logic [39:0] mean_w = sum_q >> PIX_LOG2;
	wire logic [39:0] dav_w  = dsum_q >> PIX_LOG2;
	wire logic [39:0] adv_w  = dev_q >> PIX_LOG2;
	wire logic [39:0] frac_w = {dcnt_q, 20'h0} >> PIX_LOG2;
	wire logic        rd_ok  = rd_idx < 8'(erf_pkg::NBINS);

	// The read bank is the one filled up to the last latch, so rows see a frozen copy.
	assign rd_cnt = (rd_ok && vld_q[~bank_q][rd_idx]) ? mem[~bank_q][rd_idx] : 20'h0;

	// Bins are cleared through their valid bits, so a bank swap costs one cycle.
	always_ff @(posedge core_clk) begin
		if (acc_en) begin
			mem[bank_q][bin] <= cur + 20'h1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vld_q   <= '0;
			bank_q  <= 1'b0;
			seen_q  <= 1'b0;
			first_q <= 8'h0;
			last_q  <= 8'h0;
			sum_q   <= 40'h0;
			dsum_q  <= 40'h0;
			dev_q   <= 40'h0;
			dcnt_q  <= 20'h0;
			pmean_q <= 20'h0;
			summ    <= '0;
		end else if (latch) begin
			bank_q          <= ~bank_q;
			vld_q[~bank_q]  <= '0;
			summ            <= '{mean_w[19:0], {12'h0, first_q}, {12'h0, last_q},
				dav_w[19:0], frac_w[19:0], adv_w[19:0]};
			pmean_q         <= mean_w[19:0];
			seen_q          <= 1'b0;
			sum_q           <= 40'h0;
			dsum_q          <= 40'h0;
			dev_q           <= 40'h0;
			dcnt_q          <= 20'h0;
		end else if (acc_en) begin
			vld_q[bank_q][bin] <= 1'b1;
			seen_q             <= 1'b1;
			sum_q              <= sum_q + {20'h0, acc_val};
			dev_q              <= dev_q + {20'h0, dev};
			if (!seen_q || bin < first_q) begin
				first_q <= bin;
			end
			if (!seen_q || bin > last_q) begin
				last_q <= bin;
			end
			if (dark) begin
				dsum_q <= dsum_q + {20'h0, acc_val};
				dcnt_q <= dcnt_q + 20'h1;
			end
		end
	end

endmodule : erf_stats

//--- logic/erf_formatter.sv
// Embedded row formatter: replaces lead and trail row slots with data and statistics rows.
// Assumes the sensor timing gives two extra line slots before and after the active rows,
// and a register file that answers reg_addr combinationally on the same clock.
`timescale 1ns/1ps

module erf_formatter #(
	parameter logic [11:0] ACT_ROWS = 12'h010,
	parameter int          PIX_LOG2 = 20
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Upstream video, statistics sample and embedding control
	input  wire erf_pkg::erf_vid_s src,
	input  wire logic [19:0]       stat_val,
	input  wire logic              embed_en,
	// Register file read port
	output logic [15:0]            reg_addr,
	input  wire logic [15:0]       reg_rdata,
	input  wire logic              reg_hit,
	// Downstream video
	output erf_pkg::erf_vid_s      dst
);
	erf_pkg::erf_row_e  rt;
	erf_pkg::erf_vid_s  dst_q;
	erf_pkg::erf_summ_s summ;
	logic [9:0]         wi_q;
	logic [11:0]        rc_q;
	logic               en_q;
	logic [15:0]        addr_q;
	logic [15:0]        val_q;
	logic [15:0]        fc_q;
	logic [19:0]        bin_cnt;
	logic [19:0]        sval;
	logic [11:0]        d_word;
	logic [11:0]        s1_word;
	logic [11:0]        s2_word;
	logic [11:0]        pix_w;

	function automatic logic [15:0] reg_at(input logic two, input logic [7:0] r);
		if (!two) begin
			return erf_pkg::D1_START + {7'h0, r, 1'h0};
		end
		if (r < erf_pkg::D2A_REGS) begin
			return erf_pkg::D2_START + {7'h0, r, 1'h0};
		end
		return erf_pkg::D2B_START + {7'h0, 8'(r - erf_pkg::D2A_REGS), 1'h0};
	endfunction : reg_at

	wire logic        lv_fall  = dst_q.lv & ~src.lv;
	wire logic        fv_rise  = src.fv & ~dst_q.fv;
	wire logic        is_dat   = (rt == erf_pkg::ROW_D1) || (rt == erf_pkg::ROW_D2);
	wire logic        is_stat  = (rt == erf_pkg::ROW_S1) || (rt == erf_pkg::ROW_S2);
	wire logic        is_two   = rt == erf_pkg::ROW_D2;
	wire logic [9:0]  k        = wi_q - erf_pkg::W_BODY;
	wire logic [7:0]  ridx     = k[9:2];
	wire logic [1:0]  sub      = k[1:0];
	wire logic        in_body  = wi_q >= erf_pkg::W_BODY;
	wire logic [7:0]  nregs    = is_two ? erf_pkg::D2_REGS : erf_pkg::D1_REGS;
	wire logic [15:0] start    = reg_at(is_two, 8'h00);
	wire logic [9:0]  boff     = wi_q - erf_pkg::W_BIN0;
	wire logic [9:0]  soff     = wi_q - erf_pkg::W_SUM0;
	wire logic [15:0] rdv      = reg_hit ? reg_rdata : 16'h0000;
	wire logic [11:0] s1_row   = ACT_ROWS + erf_pkg::ROWS_LEAD;
	wire logic [11:0] last_img = en_q ? s1_row - 12'h001 : ACT_ROWS - 12'h001;
	wire logic        cap      = is_dat && src.lv && in_body && sub == 2'h0 && ridx < nregs;

	// Row slots are counted, so the embedded rows inherit the upstream line timing.
	assign rt = !en_q ? erf_pkg::ROW_IMG :
		(rc_q == 12'h000) ? erf_pkg::ROW_D1 :
		(rc_q == 12'h001) ? erf_pkg::ROW_D2 :
		(rc_q == s1_row) ? erf_pkg::ROW_S1 :
		(rc_q == s1_row + 12'h001) ? erf_pkg::ROW_S2 : erf_pkg::ROW_IMG;

	assign d_word = (wi_q == erf_pkg::W_TAG) ? erf_pkg::TAG_DATA :
		(wi_q == erf_pkg::W_AMK1) ? erf_pkg::MARK_ADDR_HI :
		(wi_q == erf_pkg::W_AHI) ? erf_pkg::b8(start[15:8]) :
		(wi_q == erf_pkg::W_AMK2) ? erf_pkg::MARK_ADDR_LO :
		(wi_q == erf_pkg::W_ALO) ? erf_pkg::b8(start[7:0]) :
		(ridx < nregs && sub[0]) ? erf_pkg::b8(sub[1] ? val_q[7:0] : val_q[15:8]) :
		(ridx < nregs || (ridx == nregs && sub == 2'h0)) ? erf_pkg::MARK_VAL :
		erf_pkg::PAD_WORD;

	assign s1_word = (wi_q == erf_pkg::W_TAG) ? erf_pkg::TAG_STAT :
		(wi_q == erf_pkg::W_FMT) ? erf_pkg::w10(erf_pkg::STAT_FMT) :
		(wi_q == erf_pkg::W_CNT) ? erf_pkg::w10(erf_pkg::STAT1_WORDS) :
		(wi_q == erf_pkg::W_FCHI) ? erf_pkg::w10({2'h0, fc_q[15:8]}) :
		(wi_q == erf_pkg::W_FCLO) ? erf_pkg::w10({2'h0, fc_q[7:0]}) :
		(wi_q == erf_pkg::W_IDHI) ? erf_pkg::w10({2'h0, val_q[15:8]}) :
		(wi_q == erf_pkg::W_IDLO) ? erf_pkg::w10({2'h0, val_q[7:0]}) :
		(wi_q < erf_pkg::W_TERM1) ? erf_pkg::w10(wi_q[0] ? bin_cnt[19:10] : bin_cnt[9:0]) :
		(wi_q <= erf_pkg::W_TERM1 + 10'h001) ? erf_pkg::w10(erf_pkg::STAT_TERM) :
		erf_pkg::PAD_WORD;

	assign sval = (soff[3:1] == 3'h0) ? summ.mean :
		(soff[3:1] == 3'h1) ? summ.hist_first_nonempty :
		(soff[3:1] == 3'h2) ? summ.hist_last_nonempty :
		(soff[3:1] == 3'h3) ? summ.dark_tail_average :
		(soff[3:1] == 3'h4) ? summ.dark_tail_fraction : summ.abs_dev;

	assign s2_word = (wi_q == erf_pkg::W_TAG) ? erf_pkg::TAG_STAT :
		(wi_q == erf_pkg::W_FMT) ? erf_pkg::w10(erf_pkg::STAT_FMT) :
		(wi_q == erf_pkg::W_CNT) ? erf_pkg::w10(erf_pkg::STAT2_WORDS) :
		(wi_q < erf_pkg::W_TERM2) ? erf_pkg::w10(wi_q[0] ? sval[19:10] : sval[9:0]) :
		(wi_q == erf_pkg::W_TERM2) ? erf_pkg::w10(erf_pkg::STAT_TERM) : erf_pkg::PAD_WORD;

	assign pix_w = (rt == erf_pkg::ROW_IMG) ? src.pix : is_dat ? d_word :
		(rt == erf_pkg::ROW_S1) ? s1_word : s2_word;

	assign dst      = dst_q;
	assign reg_addr = addr_q;

	erf_stats #(
		.PIX_LOG2 (PIX_LOG2)
	) u_stats (
		.core_clk (core_clk),
		.resetn   (resetn),
		.acc_en   (src.fv && src.lv && rt == erf_pkg::ROW_IMG),
		.acc_val  (stat_val),
		.latch    (lv_fall && rc_q == last_img),
		.rd_idx   (boff[8:1]),
		.rd_cnt   (bin_cnt),
		.summ     (summ)
	);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dst_q <= '0;
			wi_q  <= 10'h000;
			rc_q  <= 12'h000;
			en_q  <= 1'b0;
		end else begin
			dst_q <= '{src.fv, src.lv, src.lv ? pix_w : erf_pkg::PAD_WORD};
			wi_q  <= !src.lv ? 10'h000 : (wi_q == '1) ? wi_q : wi_q + 10'h001;
			rc_q  <= !src.fv ? 12'h000 : lv_fall ? rc_q + 12'h001 : rc_q;
			if (fv_rise) begin
				en_q <= embed_en;
			end
		end
	end

	// The register file is addressed one cycle before its value is needed.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= 16'h0000;
			val_q  <= 16'h0000;
			fc_q   <= 16'h0000;
		end else if (is_dat && src.lv) begin
			if (wi_q == erf_pkg::W_ALO) begin
				addr_q <= reg_at(is_two, 8'h00);
			end else if (in_body && sub == 2'h3) begin
				addr_q <= reg_at(is_two, ridx + 8'h01);
			end
			if (cap) begin
				val_q <= rdv;
			end
		end else if (rt == erf_pkg::ROW_S1 && src.lv) begin
			if (wi_q == erf_pkg::W_FMT) begin
				addr_q <= erf_pkg::FCNT_ADDR;
			end else if (wi_q == erf_pkg::W_CNT) begin
				addr_q <= erf_pkg::FID_ADDR;
				fc_q   <= rdv;
			end else if (wi_q == erf_pkg::W_FCHI) begin
				val_q <= rdv;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_cap;
		cap ##1 src.lv;
	endsequence
	sequence s_hdr;
		is_dat && src.lv && wi_q == erf_pkg::W_AMK1 ##1 src.lv ##1 src.lv;
	endsequence

	AST_DATA_TAG: assert property (is_dat && src.lv && wi_q == erf_pkg::W_TAG
		|=> dst_q.pix == erf_pkg::TAG_DATA) else $error("Data row tag missing.");
	AST_DATA_NIBBLE: assert property (is_dat && src.lv
		|=> dst_q.pix[3:0] == 4'h0) else $error("Data word low nibble not zero.");
	AST_VAL_MSB: assert property (s_cap
		|=> dst_q.pix == {$past(val_q[15:8]), 4'h0}) else $error("Upper byte wrong.");
	AST_VAL_LSB: assert property (s_cap ##1 src.lv[*2]
		|=> dst_q.pix == {$past(val_q[7:0], 3), 4'h0}) else $error("Lower byte wrong.");
	AST_UNIMP_ZERO: assert property (cap && !reg_hit
		|=> val_q == 16'h0000) else $error("Unimplemented register not zero.");
	AST_ADDR_MARKS: assert property (s_hdr |=> $past(dst_q.pix, 2) == erf_pkg::MARK_ADDR_HI
		&& dst_q.pix == erf_pkg::MARK_ADDR_LO) else $error("Address markers wrong.");
	AST_ADDR_STEP: assert property (rt == erf_pkg::ROW_D1 && src.lv && in_body
		&& sub == 2'h3 && ridx + 8'h01 < nregs
		|=> addr_q == $past(addr_q) + 16'h0002) else $error("Address step not two.");
	AST_D1_START: assert property (rt == erf_pkg::ROW_D1 && src.lv && wi_q == erf_pkg::W_ALO
		|=> addr_q == erf_pkg::D1_START) else $error("Row one start wrong.");
	AST_D2_START: assert property (is_two && src.lv && wi_q == erf_pkg::W_ALO
		|=> addr_q == erf_pkg::D2_START) else $error("Row two start wrong.");
	AST_STAT_TAG: assert property (is_stat && src.lv && wi_q == erf_pkg::W_TAG
		|=> dst_q.pix == erf_pkg::TAG_STAT) else $error("Statistics tag missing.");
	AST_STAT_ALIGN: assert property (is_stat && src.lv
		|=> dst_q.pix[1:0] == 2'h0) else $error("Statistics word misaligned.");
	AST_S1_COUNT: assert property (rt == erf_pkg::ROW_S1 && src.lv && wi_q == erf_pkg::W_CNT
		|=> dst_q.pix == {erf_pkg::STAT1_WORDS, 2'h0}) else $error("Row count wrong.");
	AST_S2_COUNT: assert property (rt == erf_pkg::ROW_S2 && src.lv && wi_q == erf_pkg::W_CNT
		|=> dst_q.pix == {erf_pkg::STAT2_WORDS, 2'h0}) else $error("Row count wrong.");
	AST_FRAME_REGS: assert property (rt == erf_pkg::ROW_S1 && src.lv
		&& wi_q == erf_pkg::W_FMT ##1 src.lv |=> addr_q == erf_pkg::FID_ADDR
		&& $past(addr_q) == erf_pkg::FCNT_ADDR) else $error("Frame fields misaddressed.");
	AST_LV_TIMING: assert property ($past(resetn) |-> dst_q.lv == $past(src.lv)
		&& dst_q.fv == $past(src.fv)) else $error("Line timing not kept.");

endmodule : erf_formatter

//--- dv/erf_rx_model.sv
// Downstream receiver model with the sensor register file that feeds the formatter.
// Assumes one clock; rows are counted by falls of line valid inside frame valid.
`timescale 1ns/1ps
module erf_rx_model (
	// Clock and reset
	core_clk,
	resetn,
	// Video from the formatter
	dst,
	// Register file port
	reg_addr,
	reg_rdata,
	reg_hit
);
	input  wire logic              core_clk;
	input  wire logic              resetn;
	input  wire erf_pkg::erf_vid_s dst;
	input  wire logic [15:0]       reg_addr;
	output logic [15:0]            reg_rdata;
	output logic                   reg_hit;

	logic [11:0] cap [0:15][0:511];
	int          len [0:15];
	int          row_q;
	int          wi_q;
	logic        lv_q;
	logic        fv_q;

	// Holes sit at addresses ending in 4'he; the data lines then carry a non-zero pattern,
	// so a formatter that ignores the hit flag is caught.
	assign reg_hit   = (reg_addr[3:0] != 4'he);
	assign reg_rdata = reg_hit ? {reg_addr[7:0], ~reg_addr[7:0]} : {~reg_addr[7:0], reg_addr[7:0]};

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			row_q <= 0;
			wi_q  <= 0;
			lv_q  <= 1'b0;
			fv_q  <= 1'b0;
		end else begin
			lv_q <= dst.lv;
			fv_q <= dst.fv;
			if (dst.fv && !fv_q) begin
				row_q <= 0;
			end else if (lv_q && !dst.lv) begin
				row_q <= row_q + 1;
			end
			if (dst.lv && row_q < 16) begin
				if (wi_q < 512) begin
					cap[row_q][wi_q] <= dst.pix;
				end
				wi_q         <= wi_q + 1;
				len[row_q]   <= wi_q + 1;
			end else begin
				wi_q <= 0;
			end
		end
	end
endmodule : erf_rx_model

//--- dv/tb_top.sv
// Self-checking bench for the embedded row formatter with a shortened active area.
// Assumes the receiver model captures every line of a frame for later comparison.
`timescale 1ns/1ps
module tb_top;
	localparam logic [11:0] ACT  = 12'h004;
	localparam int          RLEN = 500;

	logic              core_clk;
	logic              resetn;
	erf_pkg::erf_vid_s src;
	erf_pkg::erf_vid_s dst;
	logic [19:0]       stat_val;
	logic              embed_en;
	logic [15:0]       reg_addr;
	logic [15:0]       reg_rdata;
	logic              reg_hit;
	int                n_errors;
	int                cmp_count;
	int                exp_bin [0:243];
	logic [19:0]       sval [0:7] = '{20'h0003f, 20'h00040, 20'h00fff, 20'h01000,
		20'h0ffff, 20'h10000, 20'hfffff, 20'h00000};

	erf_formatter #(.ACT_ROWS(ACT), .PIX_LOG2(20)) dut (.core_clk(core_clk), .resetn(resetn),
		.src(src), .stat_val(stat_val), .embed_en(embed_en), .reg_addr(reg_addr),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit), .dst(dst));
	erf_rx_model rx (.core_clk(core_clk), .resetn(resetn), .dst(dst), .reg_addr(reg_addr),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit));

	task automatic check_val(input string what, input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	function automatic logic [11:0] pix_of(input int r, input int c);
		return {r[3:0], c[7:0]};
	endfunction : pix_of

	function automatic int bin_ref(input logic [19:0] v);
		return (v < 20'h01000) ? int'(v) / 64 : (v < 20'h10000) ?
			64 + (int'(v) - 4096) / 512 : 184 + (int'(v) - 65536) / 16384;
	endfunction : bin_ref

	// Line slots are fixed length so embedded and image rows share one timing.
	task automatic drive_frame(input int nrows);
		@(negedge core_clk);
		src.fv = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int r = 0; r < nrows; r++) begin
			for (int c = 0; c < RLEN; c++) begin
				src.lv   = 1'b1;
				src.pix  = pix_of(r, c);
				stat_val = sval[c % 8];
				@(negedge core_clk);
			end
			src.lv  = 1'b0;
			src.pix = 12'h000;
			repeat (20) @(negedge core_clk);
		end
		src.fv = 1'b0;
		repeat (20) @(negedge core_clk);
	endtask : drive_frame

	task automatic chk_image_row(input int s);
		check_val("row length", 20'(rx.len[s]), 20'(RLEN));
		for (int i = 0; i < RLEN; i++) begin
			check_val("image pixel", rx.cap[s][i], pix_of(s, i));
		end
	endtask : chk_image_row

	// Only the registers whose four words fit in the line slot are compared.
	task automatic chk_data_row(input int s, input logic [15:0] a0, input int nr);
		logic [15:0] a;
		logic [15:0] v;
		int          n;
		n = (nr < (RLEN - 5) / 4) ? nr : (RLEN - 5) / 4;
		check_val("data tag", rx.cap[s][0], 12'h0a0);
		check_val("addr mark", rx.cap[s][1], 12'haa0);
		check_val("addr hi", rx.cap[s][2], {a0[15:8], 4'h0});
		check_val("addr mark", rx.cap[s][3], 12'ha50);
		check_val("addr lo", rx.cap[s][4], {a0[7:0], 4'h0});
		for (int k = 0; k < n; k++) begin
			a = a0 + 16'(2 * k);
			if (a > 16'h31bf) a = a + 16'h0010;
			v = (a[3:0] == 4'he) ? 16'h0000 : {a[7:0], ~a[7:0]};
			check_val("value mark", rx.cap[s][5 + 4 * k], 12'h5a0);
			check_val("value hi", rx.cap[s][6 + 4 * k], {v[15:8], 4'h0});
			check_val("value mark", rx.cap[s][7 + 4 * k], 12'h5a0);
			check_val("value lo", rx.cap[s][8 + 4 * k], {v[7:0], 4'h0});
		end
		if (n == nr) begin
			check_val("last mark", rx.cap[s][5 + 4 * nr], 12'h5a0);
			check_val("row pad", rx.cap[s][6 + 4 * nr], 12'h000);
		end
	endtask : chk_data_row

	task automatic chk_stats1(input int s);
		logic [19:0] n;
		check_val("stat tag", rx.cap[s][0], 12'h0b0);
		check_val("stat format", rx.cap[s][1], {10'h00b, 2'h0});
		check_val("stat count", rx.cap[s][2], {10'h1ec, 2'h0});
		check_val("count hi", rx.cap[s][3], {2'h0, 8'h3a, 2'h0});
		check_val("count lo", rx.cap[s][4], {2'h0, 8'hc5, 2'h0});
		check_val("ident hi", rx.cap[s][5], {2'h0, 8'hd2, 2'h0});
		check_val("ident lo", rx.cap[s][6], {2'h0, 8'h2d, 2'h0});
		for (int b = 0; b < 244; b++) begin
			n = 20'(exp_bin[b]);
			check_val("bin hi", rx.cap[s][7 + 2 * b], {n[19:10], 2'h0});
			check_val("bin lo", rx.cap[s][8 + 2 * b], {n[9:0], 2'h0});
		end
		check_val("end word", rx.cap[s][495], {10'h007, 2'h0});
		check_val("end word", rx.cap[s][496], {10'h007, 2'h0});
	endtask : chk_stats1

	task automatic chk_stats2(input int s, input logic [19:0] m);
		check_val("stat tag", rx.cap[s][0], 12'h0b0);
		check_val("stat format", rx.cap[s][1], 12'h02c);
		check_val("stat count", rx.cap[s][2], {10'h00c, 2'h0});
		check_val("mean hi", rx.cap[s][3], {m[19:10], 2'h0});
		check_val("mean lo", rx.cap[s][4], {m[9:0], 2'h0});
		check_val("first bin", rx.cap[s][6], 12'h000);
		check_val("last bin", rx.cap[s][8], {10'h0f3, 2'h0});
		// The first frame has no earlier mean, so nothing is dark and deviation equals the mean.
		check_val("dark avg hi", rx.cap[s][9], 12'h000);
		check_val("dark avg lo", rx.cap[s][10], 12'h000);
		check_val("dark frac hi", rx.cap[s][11], 12'h000);
		check_val("dark frac lo", rx.cap[s][12], 12'h000);
		check_val("abs dev hi", rx.cap[s][13], {m[19:10], 2'h0});
		check_val("abs dev lo", rx.cap[s][14], {m[9:0], 2'h0});
		check_val("end word", rx.cap[s][15], {10'h007, 2'h0});
		check_val("row pad", rx.cap[s][16], 12'h000);
	endtask : chk_stats2

	task automatic test_reset;
		repeat (6) @(negedge core_clk);
		check_val("video in reset", 20'(dst), 20'h00000);
		check_val("address in reset", 20'(reg_addr), 20'h00000);
		resetn = 1'b1;
		$display("test reset done");
	endtask : test_reset

	task automatic test_embedded_frame;
		longint      sum;
		logic [19:0] m;
		sum = 0;
		foreach (exp_bin[b]) exp_bin[b] = 0;
		for (int c = 0; c < RLEN; c++) begin
			exp_bin[bin_ref(sval[c % 8])] += int'(ACT);
			sum += longint'(ACT) * longint'(sval[c % 8]);
		end
		m = 20'(sum >> 20);
		embed_en = 1'b1;
		drive_frame(9);
		chk_data_row(0, 16'h3000, 152);
		chk_data_row(1, 16'h3136, 93);
		for (int s = 2; s < 6; s++) chk_image_row(s);
		chk_stats1(6);
		chk_stats2(7, m);
		chk_image_row(8);
		$display("test embedded frame done");
	endtask : test_embedded_frame

	// With the single control low no slot may be replaced.
	task automatic test_plain_frame;
		embed_en = 1'b0;
		drive_frame(8);
		for (int s = 0; s < 8; s++) chk_image_row(s);
		$display("test plain frame done");
	endtask : test_plain_frame

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		final_report();
	end

	initial begin
		resetn    = 1'b0;
		src       = '0;
		stat_val  = 20'h00000;
		embed_en  = 1'b0;
		n_errors  = 0;
		cmp_count = 0;
		test_reset();
		test_embedded_frame();
		test_plain_frame();
		final_report();
	end
endmodule : tb_top
